// >>> rtl/cpu_core_regs.sv
// cpu status word, operand registers, stack index and add/subtract execution
// Operation
// (RULE1) carry bit 7 set on carry or borrow by arithmetic, else cleared
// (RULE2) half carry bit 6 set on nibble carry or borrow, else cleared
// (RULE3) bits 5 and 1 are user storage, bit addressable, never changed by hardware
// (RULE4) bank field bits 4:3 picks register group at 0x00, 0x08, 0x10, 0x18
// (RULE5) excess bit 2 set on signed overflow, multiply or divide overflow
// (RULE6) parity bit 0 always shows odd count of ones in main operand
// (RULE7) main operand is source and destination, readable, writable, resets zero
// (RULE8) second operand feeds multiply and divide, else scratch, resets zero
// (RULE9) push increments stack index first, then writes the byte there
// (RULE10) stack index resets to 0x07 so first push lands at 0x08
// (RULE11) direct addresses below 0x80 reach data memory, above reach registers
// (RULE12) indirect address comes from bank register 0 or 1, always memory
// (RULE13) long targets are full 16-bit addresses
// (RULE14) absolute targets keep the following instruction's 2 KB page
// (RULE15) relative targets add a signed byte to the following address
// (RULE16) software writes to the status word change flags exactly as written; the code lets a same-cycle arithmetic result win for the flags it sets
// (RULE17) add opcodes 28-2F, 25, 26-27, 24 with their lengths and cycles
// (RULE18) add with carry opcodes 38-3F, 35, 36-37, 34 with their cycles
// (RULE19) subtract with borrow 98-9F is one cycle, subtracts operand and carry
// (RULE20) low three opcode bits pick bank register, lowest bit picks pointer
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module cpu_core_regs (
  input  logic                      i_clk,
  input  logic                      i_rst,
  input  logic                      i_wb_cyc,
  input  logic                      i_wb_stb,
  input  logic                      i_wb_we,
  input  logic [9:0]                i_wb_adr,
  input  logic [31:0]               i_wb_dat,
  input  logic [3:0]                i_wb_sel,
  output logic [31:0]               o_wb_dat,
  output logic                      o_wb_ack,
  input  logic                      i_op_valid,
  input  logic [7:0]                i_opcode,
  input  logic [7:0]                i_operand,
  output logic                      o_op_ready,
  output logic                      o_op_done,
  output logic                      o_op_bad,
  input  logic                      i_push_valid,
  input  logic [7:0]                i_push_data,
  output logic                      o_push_ready,
  output logic                      o_push_done,
  output logic [7:0]                o_mem_addr,
  input  logic [7:0]                i_mem_rdata,
  output logic                      o_mem_we,
  output logic [7:0]                o_mem_wdata,
  input  logic                      i_br_valid,
  input  cpu_core_pkg::branch_kind_t i_br_kind,
  input  logic [15:0]               i_br_next_pc,
  input  logic [15:0]               i_br_field,
  output logic [15:0]               o_br_target,
  output logic                      o_br_done,
  output logic [7:0]                o_status_word,
  output logic [7:0]                o_main_operand,
  output logic [7:0]                o_bank_base
);

  typedef enum logic [1:0] {
    st_idle,
    st_busy,
    st_push
  } state_t;

  state_t                state;
  logic [7:1]            status_flags;
  logic [7:0]            main_operand;
  logic [7:0]            second_operand;
  logic [7:0]            stack_top_index;
  logic [7:0]            cur_op;
  logic [7:0]            cur_operand;
  logic [7:0]            cur_ptr;
  cpu_core_pkg::form_t   cur_form;
  logic [2:0]            count;
  logic [7:0]            push_byte;
  cpu_core_pkg::form_t   take_form;
  cpu_core_pkg::form_t   exec_form;
  logic [7:0]            exec_op;
  logic [7:0]            opnd;
  logic [10:0]           alu_res;
  logic [15:0]           product;
  logic                  take;
  logic                  exec_now;
  logic                  wr_en;
  logic [7:0]            wr_idx;
  logic                  sw_status_wr;
  logic                  sw_bit_wr;

  // addressing form and operation from the opcode
  function automatic cpu_core_pkg::form_t decode_form(input logic [7:0] op);
    if (op == cpu_core_pkg::OP_PRODUCT)
      return cpu_core_pkg::FORM_MUL;
    if (op == cpu_core_pkg::OP_QUOTIENT)
      return cpu_core_pkg::FORM_DIV;
    if (op[7:4] != cpu_core_pkg::GRP_ADD && op[7:4] != cpu_core_pkg::GRP_ADD_WITH_CARRY &&
        op[7:4] != cpu_core_pkg::GRP_SUBTRACT_WITH_BORROW)
      return cpu_core_pkg::FORM_BAD;
    if (op[3])
      return cpu_core_pkg::FORM_REG; // RULE17
    if (op[3:0] == cpu_core_pkg::LO_DIR)
      return cpu_core_pkg::FORM_DIR;
    if (op[3:0] == cpu_core_pkg::LO_IND0 || op[3:0] == cpu_core_pkg::LO_IND1)
      return cpu_core_pkg::FORM_IND;
    if (op[3:0] == cpu_core_pkg::LO_IMM)
      return cpu_core_pkg::FORM_IMM;
    return cpu_core_pkg::FORM_BAD;
  endfunction

  // cycles each form occupies, the register form finishes at the taking edge
  function automatic logic [2:0] cycles_of(input cpu_core_pkg::form_t f);
    if (f == cpu_core_pkg::FORM_REG || f == cpu_core_pkg::FORM_BAD)
      return cpu_core_pkg::CYC_REG;
    if (f == cpu_core_pkg::FORM_MUL || f == cpu_core_pkg::FORM_DIV)
      return cpu_core_pkg::CYC_MULDIV;
    return cpu_core_pkg::CYC_MEM; // RULE18
  endfunction

  // special function register read, shared by bus and direct operands
  function automatic logic [7:0] sfr_read(input logic [7:0] idx, input logic [7:0] sp,
                                          input logic [7:0] sw, input logic [7:0] a,
                                          input logic [7:0] b);
    if (idx == cpu_core_pkg::IDX_STACK)
      return sp;
    if (idx == cpu_core_pkg::IDX_STATUS)
      return sw;
    if (idx == cpu_core_pkg::IDX_MAIN)
      return a;
    if (idx == cpu_core_pkg::IDX_SECOND)
      return b;
    return 8'h00;
  endfunction

  // add or subtract with carry in, result is {carry, half, excess, value}
  function automatic logic [10:0] alu(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin, input logic sub);
    logic [8:0] full;
    logic [4:0] nib;
    logic       ovf;
    full = 9'h000;
    nib  = 5'h00;
    ovf  = 1'b0;
    if (sub)
    begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin}; // RULE19
      nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      ovf  = (a[7] != b[7]) && (full[7] != a[7]);
    end
    else
    begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ovf  = (a[7] == b[7]) && (full[7] != a[7]);
    end
    return {full[8], nib[4], ovf, full[7:0]};
  endfunction

  // flag view and bank base
  assign o_status_word  = {status_flags, ^main_operand}; // RULE6
  assign o_main_operand = main_operand;
  assign o_bank_base    = {3'h0, status_flags[cpu_core_pkg::BIT_BANK_HI:cpu_core_pkg::BIT_BANK_LO],
                           3'h0}; // RULE4

  // handshakes, an instruction has priority over a push
  assign take_form    = decode_form(i_opcode);
  assign o_op_ready   = (state == st_idle);
  assign o_push_ready = (state == st_idle) && !i_op_valid;
  assign o_push_done  = (state == st_push);
  assign take         = i_op_valid && o_op_ready;
  assign exec_now     = (take && take_form == cpu_core_pkg::FORM_REG) ||
                        (state == st_busy && count == 3'h0);

  // bus write strobe: a write lands on the edge at which the master sees ack
  assign wr_idx       = i_wb_adr[9:2];
  assign wr_en        = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0] &&
                        (i_wb_adr[1:0] == 2'h0);
  assign sw_status_wr = wr_en && wr_idx == cpu_core_pkg::IDX_STATUS;
  assign sw_bit_wr    = wr_en && wr_idx == cpu_core_pkg::IDX_BIT_ACCESS;

  // data memory address: bank register, pointer register, operand, or stack slot
  always_comb
  begin
    o_mem_addr = 8'h00;
    if (state == st_idle && i_op_valid)
    begin
      if (take_form == cpu_core_pkg::FORM_REG)
        o_mem_addr = o_bank_base + {5'h00, i_opcode[2:0]}; // RULE20
      else if (take_form == cpu_core_pkg::FORM_IND)
        o_mem_addr = o_bank_base + {7'h00, i_opcode[0]}; // RULE12
    end
    else if (state == st_busy && cur_form == cpu_core_pkg::FORM_DIR)
      o_mem_addr = cur_operand; // RULE11
    else if (state == st_busy && cur_form == cpu_core_pkg::FORM_IND)
      o_mem_addr = cur_ptr; // RULE12
    else if (state == st_push)
      o_mem_addr = stack_top_index; // RULE9
  end

  assign o_mem_we    = (state == st_push);
  assign o_mem_wdata = push_byte;

  // operand fetch and arithmetic for the executing instruction
  always_comb
  begin
    exec_op   = (state == st_idle) ? i_opcode : cur_op;
    exec_form = (state == st_idle) ? take_form : cur_form;
    opnd      = i_mem_rdata;
    if (exec_form == cpu_core_pkg::FORM_IMM)
      opnd = cur_operand;
    else if (exec_form == cpu_core_pkg::FORM_DIR && cur_operand >= cpu_core_pkg::SFR_BASE)
      opnd = sfr_read(cur_operand, stack_top_index, o_status_word, main_operand,
                      second_operand); // RULE11
    alu_res = alu(main_operand, opnd,
                  (exec_op[7:4] != cpu_core_pkg::GRP_ADD) &&
                  status_flags[cpu_core_pkg::BIT_CARRY], // RULE18
                  exec_op[7:4] == cpu_core_pkg::GRP_SUBTRACT_WITH_BORROW); // RULE19
    product = main_operand * second_operand; // RULE8
  end

  // sequencing of instructions and pushes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state       <= st_idle;
      cur_op      <= 8'h00;
      cur_operand <= 8'h00;
      cur_ptr     <= 8'h00;
      cur_form    <= cpu_core_pkg::FORM_BAD;
      count       <= 3'h0;
      push_byte   <= 8'h00;
      o_op_done   <= 1'b0;
      o_op_bad    <= 1'b0;
    end
    else
    begin
      o_op_done <= exec_now || (take && take_form == cpu_core_pkg::FORM_BAD);
      o_op_bad  <= take && take_form == cpu_core_pkg::FORM_BAD;
      unique case (state)
        st_idle:
        begin
          if (take)
          begin
            cur_op      <= i_opcode;
            cur_operand <= i_operand;
            cur_form    <= take_form;
            cur_ptr     <= i_mem_rdata; // pointer register value, used next cycle
            count       <= cycles_of(take_form) - 3'h2;
            if (cycles_of(take_form) != cpu_core_pkg::CYC_REG)
              state <= st_busy; // RULE17
          end
          else if (i_push_valid)
          begin
            push_byte <= i_push_data;
            state     <= st_push;
          end
        end
        st_busy:
        begin
          count <= count - 3'h1;
          if (count == 3'h0)
            state <= st_idle;
        end
        st_push:
          state <= st_idle;
      endcase
    end
  end

  // status flags: arithmetic result wins over a software write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      status_flags <= cpu_core_pkg::RST_STATUS[7:1];
    else
    begin
      if (sw_status_wr)
        status_flags <= i_wb_dat[7:1]; // RULE16
      else if (sw_bit_wr && i_wb_dat[2:0] != 3'h0)
        status_flags[i_wb_dat[2:0]] <= i_wb_dat[cpu_core_pkg::BA_VALUE]; // RULE3
      if (exec_now && exec_form == cpu_core_pkg::FORM_MUL)
      begin
        status_flags[cpu_core_pkg::BIT_CARRY]  <= 1'b0;
        status_flags[cpu_core_pkg::BIT_EXCESS] <= (product[15:8] != 8'h00); // RULE5
      end
      else if (exec_now && exec_form == cpu_core_pkg::FORM_DIV)
      begin
        status_flags[cpu_core_pkg::BIT_CARRY]  <= 1'b0;
        status_flags[cpu_core_pkg::BIT_EXCESS] <= (second_operand == 8'h00); // RULE5
      end
      else if (exec_now)
      begin
        status_flags[cpu_core_pkg::BIT_CARRY]  <= alu_res[10]; // RULE1
        status_flags[cpu_core_pkg::BIT_HALF]   <= alu_res[9]; // RULE2
        status_flags[cpu_core_pkg::BIT_EXCESS] <= alu_res[8]; // RULE5
      end
    end
  end

  // operand registers, execution wins over a software write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      main_operand   <= cpu_core_pkg::RST_MAIN; // RULE7
      second_operand <= cpu_core_pkg::RST_SECOND; // RULE8
    end
    else
    begin
      if (wr_en && wr_idx == cpu_core_pkg::IDX_MAIN)
        main_operand <= i_wb_dat[7:0]; // RULE7
      if (wr_en && wr_idx == cpu_core_pkg::IDX_SECOND)
        second_operand <= i_wb_dat[7:0]; // RULE8
      if (exec_now && exec_form == cpu_core_pkg::FORM_MUL)
      begin
        main_operand   <= product[7:0];
        second_operand <= product[15:8]; // RULE8
      end
      else if (exec_now && exec_form == cpu_core_pkg::FORM_DIV && second_operand != 8'h00)
      begin
        main_operand   <= main_operand / second_operand;
        second_operand <= main_operand % second_operand;
      end
      else if (exec_now && exec_form != cpu_core_pkg::FORM_DIV)
        main_operand <= alu_res[7:0]; // RULE7
    end
  end

  // stack index, a push increments before the write cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      stack_top_index <= cpu_core_pkg::RST_STACK; // RULE10
    else if (i_push_valid && o_push_ready)
      stack_top_index <= stack_top_index + 8'h01; // RULE9
    else if (wr_en && wr_idx == cpu_core_pkg::IDX_STACK)
      stack_top_index <= i_wb_dat[7:0];
  end

  // wishbone slave: ack one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      if (i_wb_cyc && i_wb_stb && !o_wb_ack)
        o_wb_dat <= (i_wb_adr[1:0] != 2'h0) ? 32'h00000000 :
                    {24'h000000, sfr_read(i_wb_adr[9:2], stack_top_index, o_status_word,
                                          main_operand, second_operand)};
    end
  end

  branch_target_unit branch_unit (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_valid   (i_br_valid),
    .i_kind    (i_br_kind),
    .i_next_pc (i_br_next_pc),
    .i_field   (i_br_field),
    .o_target  (o_br_target),
    .o_done    (o_br_done)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_push_take;
    i_push_valid && o_push_ready;
  endsequence
  sequence s_push_write(logic [7:0] sp0);
    o_mem_we && o_mem_addr == sp0 + 8'h01 ##1 !o_mem_we;
  endsequence

  a_parity_live: assert property (o_status_word[0] == ^o_main_operand) // RULE6
    else $error("parity does not follow main operand");
  a_carry_result: assert property (exec_now && exec_form != cpu_core_pkg::FORM_MUL && // RULE1
    exec_form != cpu_core_pkg::FORM_DIV |=> o_status_word[7] == $past(alu_res[10]))
    else $error("carry flag wrong after arithmetic");
  a_half_result: assert property (exec_now && exec_form != cpu_core_pkg::FORM_MUL && // RULE2
    exec_form != cpu_core_pkg::FORM_DIV |=> o_status_word[6] == $past(alu_res[9]))
    else $error("half carry flag wrong after arithmetic");
  a_excess_result: assert property (exec_now && exec_form == cpu_core_pkg::FORM_MUL // RULE5
    |=> o_status_word[2] == ($past(product[15:8]) != 8'h00) && !o_status_word[7])
    else $error("excess flag wrong after multiply");
  a_user_bits_hold: assert property (!sw_status_wr && !sw_bit_wr |=> // RULE3
    $stable(o_status_word[5]) && $stable(o_status_word[1])) else $error("user bit changed");
  a_status_write: assert property (sw_status_wr && !exec_now |=> // RULE16
    o_status_word[7:1] == $past(i_wb_dat[7:1])) else $error("status write not exact");
  a_bank_base: assert property (o_bank_base[2:0] == 3'h0 && // RULE4
    o_bank_base[4:3] == o_status_word[4:3]) else $error("bank base wrong");
  a_push_order: assert property (s_push_take |=> s_push_write($past(stack_top_index))) // RULE9
    else $error("push did not increment then write");
  a_reset_values: assert property (disable iff (1'b0) i_rst |=> stack_top_index == // RULE10
    cpu_core_pkg::RST_STACK && main_operand == 8'h00 && second_operand == 8'h00)
    else $error("reset values wrong");
  a_reg_one_cycle: assert property (take && take_form == cpu_core_pkg::FORM_REG |=> // RULE19
    o_op_done && o_op_ready) else $error("register form not one cycle");
  a_mem_two_cycle: assert property (take && cycles_of(take_form) == cpu_core_pkg::CYC_MEM // RULE17
    |=> !o_op_done ##1 o_op_done) else $error("memory form not two cycles");
  a_muldiv_timing: assert property (take && take_form == cpu_core_pkg::FORM_MUL |=> // RULE8
    !o_op_done [*4] ##1 o_op_done) else $error("multiply not five cycles");
  a_direct_memory: assert property (state == st_busy && cur_form == cpu_core_pkg::FORM_DIR // RULE11
    && cur_operand < cpu_core_pkg::SFR_BASE |-> o_mem_addr == cur_operand)
    else $error("direct address not sent to memory");
  a_indirect_pointer: assert property (take && take_form == cpu_core_pkg::FORM_IND |=> // RULE12
    o_mem_addr == $past(i_mem_rdata)) else $error("indirect address not from pointer");
  a_reg_select: assert property (take && take_form == cpu_core_pkg::FORM_REG |-> // RULE20
    o_mem_addr[2:0] == i_opcode[2:0] && o_mem_addr[7:3] == o_bank_base[7:3])
    else $error("bank register select wrong");

endmodule

// >>> rtl/cpu_core_pkg.sv
// constants and types shared by the cpu core register and flag logic
package cpu_core_pkg;

  // special function register indices, byte address on the bus is four times the index
  localparam logic [7:0] IDX_STACK      = 8'h81;
  localparam logic [7:0] IDX_STATUS     = 8'hD0;
  localparam logic [7:0] IDX_MAIN       = 8'hE0;
  localparam logic [7:0] IDX_SECOND     = 8'hF0;
  localparam logic [7:0] IDX_BIT_ACCESS = 8'h01;
  localparam logic [7:0] SFR_BASE       = 8'h80;

  // reset values
  localparam logic [7:0] RST_STACK  = 8'h07;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MAIN   = 8'h00;
  localparam logic [7:0] RST_SECOND = 8'h00;

  // status word field positions
  localparam int BIT_CARRY    = 7;
  localparam int BIT_HALF     = 6;
  localparam int BIT_USER_HI  = 5;
  localparam int BIT_BANK_HI  = 4;
  localparam int BIT_BANK_LO  = 3;
  localparam int BIT_EXCESS   = 2;
  localparam int BIT_USER_LO  = 1;
  localparam int BIT_PARITY   = 0;

  // bit access register layout: bit number in [2:0], value in [3]
  localparam int BA_VALUE = 3;

  // opcode groups (upper nibble) and addressing forms (lower nibble)
  localparam logic [3:0] GRP_ADD  = 4'h2;
  localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] LO_IMM   = 4'h4;
  localparam logic [3:0] LO_DIR   = 4'h5;
  localparam logic [3:0] LO_IND0  = 4'h6;
  localparam logic [3:0] LO_IND1  = 4'h7;
  localparam logic [7:0] OP_PRODUCT  = 8'hA4;
  localparam logic [7:0] OP_QUOTIENT = 8'h84;

  // execution cycles per form
  localparam logic [2:0] CYC_REG    = 3'h1;
  localparam logic [2:0] CYC_MEM    = 3'h2;
  localparam logic [2:0] CYC_MULDIV = 3'h5;

  typedef enum logic [2:0] {
    FORM_REG,
    FORM_DIR,
    FORM_IND,
    FORM_IMM,
    FORM_MUL,
    FORM_DIV,
    FORM_BAD
  } form_t;

  typedef enum logic [1:0] {
    BR_LONG,
    BR_ABS,
    BR_REL
  } branch_kind_t;

endpackage

// >>> rtl/branch_target_unit.sv
// branch target arithmetic for long, absolute and relative jumps
`timescale 1ns/1ps
module branch_target_unit (
  input  logic                      i_clk,
  input  logic                      i_rst,
  input  logic                      i_valid,
  input  cpu_core_pkg::branch_kind_t i_kind,
  input  logic [15:0]               i_next_pc,
  input  logic [15:0]               i_field,
  output logic [15:0]               o_target,
  output logic                      o_done
);

  logic [15:0] next_target;

  // target selection by jump kind
  always_comb
  begin
    next_target = i_field; // RULE13
    unique case (i_kind)
      cpu_core_pkg::BR_LONG: next_target = i_field;
      cpu_core_pkg::BR_ABS:  next_target = {i_next_pc[15:11], i_field[10:0]}; // RULE14
      cpu_core_pkg::BR_REL:  next_target = i_next_pc + {{8{i_field[7]}}, i_field[7:0]}; // RULE15
      default:               next_target = i_field;
    endcase
  end

  // registered result, one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_target <= 16'h0000;
      o_done   <= 1'b0;
    end
    else
    begin
      o_done <= i_valid;
      if (i_valid)
        o_target <= next_target;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_long_target: assert property (i_valid && i_kind == cpu_core_pkg::BR_LONG |=> // RULE13
    o_done && o_target == $past(i_field)) else $error("long target wrong");
  a_abs_page: assert property (i_valid && i_kind == cpu_core_pkg::BR_ABS |=> // RULE14
    o_target[15:11] == $past(i_next_pc[15:11]) && o_target[10:0] == $past(i_field[10:0]))
    else $error("absolute target left its page");
  a_rel_offset: assert property (i_valid && i_kind == cpu_core_pkg::BR_REL |=> // RULE15
    (o_target - $past(i_next_pc)) == {{8{$past(i_field[7])}}, $past(i_field[7:0])})
    else $error("relative target offset wrong");

endmodule

// >>> sim/tb.sv
// self-checking bench for the cpu core register and flag logic
`timescale 1ns/1ps
module tb;
  logic        i_clk = 0;
  logic        i_rst = 1;
  logic        cyc = 0, stb = 0, we = 0, opv = 0, pv = 0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h00000000, rd;
  logic [3:0]  sel = 4'hF, grp, lo;
  logic [7:0]  opc = 8'h00, opd = 8'h00, pd = 8'h00;
  logic [7:0]  mrd, q, ma, sw, sb, x, d, madr, mwd, swo, mao, bb;
  logic [7:0]  mem [256];
  logic        ack, rdy, dn, bad, prdy, pdn, mwe;
  logic        brv = 0, bdn;
  logic [15:0] bpc = 16'h0000, bfd = 16'h0000, btg;
  cpu_core_pkg::branch_kind_t brk = cpu_core_pkg::BR_LONG;
  int          n_errors = 0, n_compared = 0, seed = 46, n, i, a, bv, c, r, h, v, cy;

  always #50 i_clk = ~i_clk;
  // data memory answers in the same cycle, push writes land on the edge
  assign mrd = mem[madr];
  always @(posedge i_clk) if (mwe === 1'b1) mem[madr] <= mwd;

  cpu_core_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rd),
    .o_wb_ack(ack), .i_op_valid(opv), .i_opcode(opc), .i_operand(opd), .o_op_ready(rdy),
    .o_op_done(dn), .o_op_bad(bad), .i_push_valid(pv), .i_push_data(pd),
    .o_push_ready(prdy), .o_push_done(pdn), .o_mem_addr(madr), .i_mem_rdata(mrd),
    .o_mem_we(mwe), .o_mem_wdata(mwd), .i_br_valid(brv), .i_br_kind(brk),
    .i_br_next_pc(bpc), .i_br_field(bfd), .o_br_target(btg), .o_br_done(bdn),
    .o_status_word(swo), .o_main_operand(mao),
    .o_bank_base(bb));

  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every wait is bounded so a hung handshake ends the run
  task automatic step();
    @(posedge i_clk);
    n++;
    if (n > 50)
    begin
      n_errors++;
      final_report();
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [9:0] ad, input logic [7:0] wd);
    @(posedge i_clk);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, ad, 24'h000000, wd};
    n = 0;
    do step(); while (ack !== 1'b1);
    q = rd[7:0];
    {cyc, stb} <= 2'b00;
    // a write lands on the ack edge, so look only once it has settled
    #1;
  endtask
  // n ends as cycles from take to done
  task automatic op(input logic [7:0] o, input logic [7:0] od);
    @(posedge i_clk);
    {opv, opc, opd} <= {1'b1, o, od};
    n = 0;
    do step(); while (rdy !== 1'b1);
    opv <= 1'b0;
    #1;
    n = 1;
    while (dn !== 1'b1)
    begin
      step();
      #1;
    end
  endtask
  // operand as the addressing form selects it
  function automatic logic [7:0] fetch(input logic [3:0] f, input logic [7:0] od);
    case (f)
      4'h4: return od;
      4'h5: return (od == 8'hF0) ? sb : mem[od];
      4'h6, 4'h7: return mem[mem[{3'b000, sw[4:3], 2'b00, f[0]}]];
      default: return mem[{3'b000, sw[4:3], f[2:0]}];
    endcase
  endfunction

  initial
  begin
    for (i = 0; i < 256; i++)
      mem[i] = $random(seed);
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, an unmapped place, scratch storage
    wb(0, 10'h204, 8'h00); chk(q, 8'h07);
    wb(0, 10'h380, 8'h00); chk(q, 8'h00);
    wb(0, 10'h3C0, 8'h00); chk(q, 8'h00);
    wb(0, 10'h008, 8'h00); chk(q, 8'h00);
    sb = $random(seed);
    wb(1, 10'h3C0, sb);
    wb(0, 10'h3C0, 8'h00); chk(q, sb);
    // first push after reset lands at 0x08
    x = $random(seed);
    @(posedge i_clk);
    {pv, pd} <= {1'b1, x};
    n = 0;
    do step(); while (prdy !== 1'b1);
    pv <= 1'b0;
    #1;
    chk({mwe, pdn, madr}, {2'b11, 8'h08});
    chk(mwd, x);
    wb(0, 10'h204, 8'h00); chk(q, 8'h08);
    // user bits set one at a time through bit access
    wb(1, 10'h340, 8'h00);
    wb(1, 10'h004, 8'h0D);
    wb(1, 10'h004, 8'h09);
    chk(swo & 8'h22, 8'h22);
    // random add, add with carry, subtract with borrow in every form
    for (i = 0; i < 60; i++)
    begin
      sw = $random(seed);
      ma = $random(seed);
      wb(1, 10'h340, sw);
      wb(1, 10'h380, ma);
      chk(swo, {sw[7:1], ^ma});
      chk(bb, {3'b000, sw[4:3], 3'b000});
      x = $random(seed);
      grp = x[5] ? 4'h9 : (x[4] ? 4'h3 : 4'h2);
      lo = x[3] ? {1'b1, x[2:0]} : {2'b01, x[1:0]};
      d = x[6] ? 8'hF0 : $random(seed) & 8'h7F;
      a = ma;
      bv = fetch(lo, d);
      c = (grp == 4'h2) ? 0 : sw[7];
      r = (grp == 4'h9) ? a - bv - c : a + bv + c;
      h = (grp == 4'h9) ? (a % 16 < bv % 16 + c) : (a % 16 + bv % 16 + c > 15);
      cy = (r < 0) || (r > 255);
      v = (((a ^ bv) & 128) == ((grp == 4'h9) ? 128 : 0)) && ((a ^ r) & 128) != 0;
      ma = r[7:0];
      sw = {cy[0], h[0], sw[5:3], v[0], sw[1], 1'b0};
      op({grp, lo}, d);
      chk(n[7:0], lo[3] ? 8'h01 : 8'h02);
      chk(mao, ma);
      chk(swo, {sw[7:1], ^ma});
    end
    // product uses the second operand, high byte returns there
    a = ma * sb;
    op(8'hA4, 8'h00);
    chk(n[7:0], 8'h05);
    chk(mao, a[7:0]);
    chk(swo, {1'b0, sw[6:3], a > 255, sw[1], ^a[7:0]});
    wb(0, 10'h3C0, 8'h00); chk(q, a[15:8]);
    // divide the product back, quotient to main and remainder to second
    ma = a[7:0];
    sb = a[15:8];
    op(8'h84, 8'h00);
    r = (sb == 0) ? ma : ma / sb;
    c = (sb == 0) ? sb : ma % sb;
    chk(n[7:0], 8'h05);
    chk(mao, r[7:0]);
    chk(swo, {1'b0, sw[6:3], sb == 8'h00, sw[1], ^r[7:0]});
    wb(0, 10'h3C0, 8'h00); chk(q, c[7:0]);
    // an opcode outside the handled groups is refused with no effect
    op(8'h00, 8'h00);
    chk(n[7:0], 8'h01);
    chk({7'h00, bad}, 8'h01);
    chk(mao, r[7:0]);
    // branch targets of each kind, done one cycle after the request
    for (i = 0; i < 12; i++)
    begin
      @(posedge i_clk);
      h = $random(seed);
      v = $random(seed);
      {brv, bpc, bfd} <= {1'b1, h[15:0], v[15:0]};
      brk <= cpu_core_pkg::branch_kind_t'(i % 3);
      @(posedge i_clk);
      brv <= 1'b0;
      #1;
      r = (i % 3 == 0) ? v : ((i % 3 == 1) ? {h[15:11], v[10:0]} :
                              h + v[7:0] - (v[7] ? 256 : 0));
      chk({15'h0000, bdn}, 16'h0001);
      chk(btg, r[15:0]);
    end
    final_report();
  end
endmodule
